// *** inc/pisoshift_pkg.sv ***
// constants for the parallel-in serial-out shifter and its output stream fifo
package pisoshift_pkg;
  localparam int STAGE_COUNT = 8;
  localparam int MSB_POS = 7;
  localparam int SYNC_DEPTH = 3;
  localparam logic [7:0] STAGE_RESET = 8'h00;
  localparam logic [2:0] SYNC_RESET = 3'h0;
  localparam int STREAM_WIDTH = 1;
  localparam int STREAM_DEPTH = 8;
  localparam int STREAM_CNT_W = 4;
  localparam int CLOCK_PERIOD_NS = 20;

  typedef enum logic [1:0] {
    LOAD_type_HOLD = 2'b01,
    LOAD_type_LOAD = 2'b10
  } load_state_type;
endpackage : pisoshift_pkg

// *** rtl/pisoshift.sv ***
// parallel-in serial-out shifter with gated dual shift clocks and output stream fifo
`timescale 1ns/1ps

module stream_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8,
  parameter int CNT_W = 4
) (
  input wire logic i_clock, // system clock
  input wire logic i_rstn, // async reset, active low
  input wire logic i_ce, // clock enable
  input wire logic i_in_valid, // write request
  output logic o_in_ready, // room for a word
  input wire logic [WIDTH-1:0] i_in_data, // word written
  output logic o_out_valid, // head word present
  input wire logic i_out_ready, // reader takes head
  output logic [WIDTH-1:0] o_out_data // head word
);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [CNT_W-1:0] count_ff;
  logic valid_ff;
  logic ready_ff;
  logic push;
  logic pop;
  logic [CNT_W-1:0] nxt_count;
  logic [CNT_W-1:0] wr_idx;

  assign push = i_in_valid && ready_ff;
  assign pop = valid_ff && i_out_ready;
  assign nxt_count = count_ff + CNT_W'(push) - CNT_W'(pop);
  // head always lives in entry zero, so the read port is a flop
  assign wr_idx = pop ? count_ff - CNT_W'(1) : count_ff;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      count_ff <= '0;
      valid_ff <= 1'b0;
      ready_ff <= 1'b1;
    end else if (i_ce) begin
      count_ff <= nxt_count;
      valid_ff <= nxt_count != '0;
      ready_ff <= nxt_count != CNT_W'(DEPTH);
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
    end else if (i_ce) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (push && CNT_W'(i) == wr_idx) begin
          mem_ff[i] <= i_in_data;
        end else if (pop) begin
          mem_ff[i] <= (i == DEPTH - 1) ? '0 : mem_ff[(i + 1) % DEPTH];
        end
      end
    end
  end

  // ready is its own flop so the top's stream_ready comes straight from a register
  assign o_in_ready = ready_ff;
  assign o_out_valid = valid_ff;
  assign o_out_data = mem_ff[0];

  property p_count_bound;
    @(posedge i_clock) disable iff (!i_rstn)
    (count_ff <= CNT_W'(DEPTH)) && (ready_ff == (count_ff != CNT_W'(DEPTH)));
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("stream fifo count out of step");
endmodule : stream_fifo

////////////////////////////////////////////////////////////////////////////////

module pisoshift
  import pisoshift_pkg::*;
(
  input wire logic i_clock, // system clock, 50 MHz
  input wire logic i_rstn, // async reset, active low
  input wire logic i_ce, // clock enable, freezes all state when low
  input wire logic i_load_n, // parallel load, active low
  input wire logic [7:0] i_par_in, // parallel data
  input wire logic i_serial_in, // serial data into the low stage
  input wire logic i_shift_clk_a, // first shift clock or enable
  input wire logic i_shift_clk_b, // second shift clock or enable
  output logic o_msb_out, // top stage
  output logic o_msb_out_n, // top stage inverted
  output logic o_stream_ready, // stream fifo has room, shifts stall when low
  output logic o_stream_valid, // shifted-out bit available
  output logic o_stream_bit, // oldest shifted-out bit
  input wire logic i_stream_ready // consumer takes stream bit
);
  localparam int SYNC_N = 12;

  logic [SYNC_N-1:0] sync1_ff;
  logic [SYNC_N-1:0] sync2_ff;
  logic [SYNC_N-1:0] sync3_ff;
  logic [SYNC_N-1:0] filt_ff;
  logic f_load_n;
  logic f_clk_a;
  logic f_clk_b;
  logic f_serial;
  logic [7:0] f_par;
  logic comb_clk;
  logic comb_prev_ff;
  logic clk_edge;
  logic fifo_ready;
  logic shift_go;
  logic [7:0] stage_ff;
  logic [7:0] nxt_stage;
  logic msb_n_ff;
  load_state_type load_state;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a change is accepted once stages two and three agree

  function automatic logic [SYNC_N-1:0] agree_filter(input logic [SYNC_N-1:0] a,
                                                     input logic [SYNC_N-1:0] b,
                                                     input logic [SYNC_N-1:0] held);
    agree_filter = (a & b) | (held & (a | b));
  endfunction : agree_filter

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_ff <= {SYNC_N{1'b1}};
      sync2_ff <= {SYNC_N{1'b1}};
      sync3_ff <= {SYNC_N{1'b1}};
      filt_ff <= {SYNC_N{1'b1}};
    end else if (i_ce) begin
      sync1_ff <= {i_load_n, i_shift_clk_a, i_shift_clk_b, i_serial_in, i_par_in};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      filt_ff <= agree_filter(sync2_ff, sync3_ff, filt_ff);
    end
  end

  assign {f_load_n, f_clk_a, f_clk_b, f_serial, f_par} = filt_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // merged shift clock and shift decision

  assign comb_clk = f_clk_a | f_clk_b;
  // a clock already high masks the other's rising edge
  assign clk_edge = comb_clk && !comb_prev_ff;
  assign load_state = f_load_n ? LOAD_type_HOLD : LOAD_type_LOAD;
  // a full stream fifo stalls the chain rather than losing a bit
  assign shift_go = (load_state == LOAD_type_HOLD) && clk_edge && fifo_ready;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      comb_prev_ff <= 1'b1;
    end else if (i_ce) begin
      comb_prev_ff <= comb_clk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // stage chain

  always_comb begin
    case (load_state)
      LOAD_type_LOAD: nxt_stage = f_par;
      LOAD_type_HOLD: nxt_stage = shift_go ? {stage_ff[6:0], f_serial} : stage_ff;
      default: nxt_stage = stage_ff;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      stage_ff <= STAGE_RESET;
      msb_n_ff <= ~STAGE_RESET[MSB_POS];
    end else if (i_ce) begin
      stage_ff <= nxt_stage;
      msb_n_ff <= ~nxt_stage[MSB_POS];
    end
  end

  assign o_msb_out = stage_ff[MSB_POS];
  assign o_msb_out_n = msb_n_ff;
  assign o_stream_ready = fifo_ready;

  ////////////////////////////////////////////////////////////////////////////////
  // bits leaving the top stage queue for the consumer

  stream_fifo #(
    .WIDTH(STREAM_WIDTH),
    .DEPTH(STREAM_DEPTH),
    .CNT_W(STREAM_CNT_W)
  ) u_stream_fifo (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_in_valid(shift_go),
    .o_in_ready(fifo_ready),
    .i_in_data(stage_ff[MSB_POS]),
    .o_out_valid(o_stream_valid),
    .i_out_ready(i_stream_ready),
    .o_out_data(o_stream_bit)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  property p_hold_stable;
    @(posedge i_clock) disable iff (!i_rstn)
    (i_ce && f_load_n && !shift_go) |=> $stable(stage_ff);
  endproperty
  a_hold_stable: assert property (p_hold_stable) else $error("stages moved without a shift");

  property p_load_copy;
    @(posedge i_clock) disable iff (!i_rstn)
    (i_ce && !f_load_n) |=> (stage_ff == $past(f_par));
  endproperty
  a_load_copy: assert property (p_load_copy) else $error("load did not copy parallel data");

  property p_load_blocks;
    @(posedge i_clock) disable iff (!i_rstn)
    (i_ce && !f_load_n && !comb_prev_ff && comb_clk)
      |-> !shift_go ##1 (stage_ff == $past(f_par));
  endproperty
  a_load_blocks: assert property (p_load_blocks) else $error("shift during load");

  property p_complement;
    @(posedge i_clock) disable iff (!i_rstn)
    1'b1 |=> (o_msb_out_n == !o_msb_out) && (o_msb_out == stage_ff[MSB_POS]);
  endproperty
  a_complement: assert property (p_complement) else $error("serial outputs not complementary");

  property p_serial_entry;
    @(posedge i_clock) disable iff (!i_rstn)
    (i_ce && shift_go) |=> (stage_ff[0] == $past(f_serial));
  endproperty
  a_serial_entry: assert property (p_serial_entry) else $error("serial input not captured");

  property p_edge_shifts;
    @(posedge i_clock) disable iff (!i_rstn)
    (i_ce && f_load_n && fifo_ready && !f_clk_b && $rose(f_clk_a) && !comb_prev_ff)
      |-> shift_go ##1 (stage_ff[7:1] == $past(stage_ff[6:0]));
  endproperty
  a_edge_shifts: assert property (p_edge_shifts) else $error("rising clock did not shift");

  property p_either_clock;
    @(posedge i_clock) disable iff (!i_rstn)
    (f_load_n && fifo_ready && !comb_prev_ff && (f_clk_a || f_clk_b)) |-> shift_go;
  endproperty
  a_either_clock: assert property (p_either_clock) else $error("clock b edge ignored");

  property p_disable_holds;
    @(posedge i_clock) disable iff (!i_rstn)
    (i_ce && f_load_n && comb_prev_ff && f_clk_b && $past(f_clk_b))
      |-> !shift_go ##1 $stable(stage_ff[7:1]);
  endproperty
  a_disable_holds: assert property (p_disable_holds) else $error("shift while disabled");

  property p_ce_freeze;
    @(posedge i_clock) disable iff (!i_rstn)
    !i_ce |=> $stable(stage_ff) && $stable(o_msb_out_n);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state changed with enable low");

  // a full fifo drops the shift edge rather than losing the bit
  property p_stall_holds;
    @(posedge i_clock) disable iff (!i_rstn)
    (i_ce && f_load_n && !fifo_ready) |=> $stable(stage_ff);
  endproperty
  a_stall_holds: assert property (p_stall_holds) else $error("chain moved with stream fifo full");

  property p_push_bit;
    @(posedge i_clock) disable iff (!i_rstn)
    (i_ce && shift_go && !o_stream_valid)
      |=> o_stream_valid && (o_stream_bit == $past(o_msb_out));
  endproperty
  a_push_bit: assert property (p_push_bit) else $error("shifted-out bit not queued");

  // shifts since the last load, read only by the coverage below
  logic [3:0] shift_cnt_ff;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      shift_cnt_ff <= 4'h0;
    end else if (i_ce) begin
      if (load_state == LOAD_type_LOAD) begin
        shift_cnt_ff <= 4'h0;
      end else if (shift_go && shift_cnt_ff != 4'(STAGE_COUNT)) begin
        shift_cnt_ff <= shift_cnt_ff + 4'h1;
      end
    end
  end

  c_load: cover property (@(posedge i_clock) disable iff (!i_rstn) !f_load_n ##1 f_load_n);
  c_shift8: cover property (@(posedge i_clock) disable iff (!i_rstn)
    shift_cnt_ff == 4'(STAGE_COUNT));
  c_disabled: cover property (@(posedge i_clock) disable iff (!i_rstn)
    f_clk_b && $rose(f_clk_a));
  c_fifo_full: cover property (@(posedge i_clock) disable iff (!i_rstn) !fifo_ready);
endmodule : pisoshift

// *** bench/stream_sink.sv ***
// consumer model for the shifted-out bit stream
`timescale 1ns/1ps

module stream_sink (
  input wire logic i_clock, // system clock
  input wire logic i_rstn, // async reset, active low
  input wire logic i_stall, // hold off taking bits
  input wire logic i_valid, // bit on offer
  input wire logic i_bit, // offered bit
  output logic o_ready, // taking bits
  output logic [7:0] o_word, // last eight bits taken, newest low
  output logic [7:0] o_count // bits taken, wraps
);
  assign o_ready = ~i_stall;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_word <= 8'h00;
      o_count <= 8'h00;
    end else if (i_valid && o_ready) begin
      o_word <= {o_word[6:0], i_bit};
      o_count <= o_count + 8'h01;
    end
  end
endmodule : stream_sink

// *** bench/pisoshift_tb_top.sv ***
// self-checking bench for the shifter and its stream fifo
`timescale 1ns/1ps

module pisoshift_tb_top;
  import pisoshift_pkg::*;
  logic i_clock = 1'b0;
  logic i_rstn = 1'b0;
  logic i_ce = 1'b1;
  logic i_load_n = 1'b1;
  logic i_serial_in = 1'b0;
  logic i_shift_clk_a = 1'b0;
  logic i_shift_clk_b = 1'b0;
  logic stall = 1'b0;
  logic [7:0] i_par_in = 8'h00;
  logic o_msb_out, o_msb_out_n, o_stream_ready, o_stream_valid, o_stream_bit, i_stream_ready;
  logic [7:0] sink_word, sink_count;
  int miscompares = 0;
  int n_compared = 0;

  always #(CLOCK_PERIOD_NS / 2) i_clock = ~i_clock;

  pisoshift u_pisoshift (.i_clock(i_clock), .i_rstn(i_rstn), .i_ce(i_ce), .i_load_n(i_load_n),
    .i_par_in(i_par_in), .i_serial_in(i_serial_in), .i_shift_clk_a(i_shift_clk_a),
    .i_shift_clk_b(i_shift_clk_b), .o_msb_out(o_msb_out), .o_msb_out_n(o_msb_out_n),
    .o_stream_ready(o_stream_ready), .o_stream_valid(o_stream_valid),
    .o_stream_bit(o_stream_bit), .i_stream_ready(i_stream_ready));
  stream_sink u_stream_sink (.i_clock(i_clock), .i_rstn(i_rstn), .i_stall(stall),
    .i_valid(o_stream_valid), .i_bit(o_stream_bit), .o_ready(i_stream_ready),
    .o_word(sink_word), .o_count(sink_count));

  ////////////////////////////////////////////////////////////////////////////////

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
  endtask : cyc

  task automatic chk(input logic [7:0] exp, input logic [7:0] got, input string what);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // both outputs at once, the complement must always track
  task automatic chk_msb(input logic exp);
    chk({7'h00, exp}, {7'h00, o_msb_out}, "msb");
    chk({7'h00, ~exp}, {7'h00, o_msb_out_n}, "msb inverted");
  endtask : chk_msb

  // high and low 4 cycles each, longer than the 3-edge input filter
  task automatic pulse(input logic use_b);
    @(posedge i_clock);
    if (use_b) i_shift_clk_b <= 1'b1;
    else i_shift_clk_a <= 1'b1;
    cyc(4);
    if (use_b) i_shift_clk_b <= 1'b0;
    else i_shift_clk_a <= 1'b0;
    cyc(4);
  endtask : pulse

  task automatic load(input logic [7:0] p);
    @(posedge i_clock);
    i_par_in <= p;
    i_load_n <= 1'b0;
    cyc(6);
    i_load_n <= 1'b1;
    cyc(5);
  endtask : load

  task automatic t_load;
    @(posedge i_clock);
    i_par_in <= 8'h6d;
    i_load_n <= 1'b0;
    cyc(5);
    pulse(1'b0);
    chk_msb(1'b0);
    i_par_in <= 8'h9d;
    cyc(5);
    pulse(1'b1);
    chk_msb(1'b1);
    i_load_n <= 1'b1;
    cyc(5);
    chk_msb(1'b1);
  endtask : t_load

  task automatic t_shift(input logic [7:0] p, input logic [7:0] s, input logic use_b);
    logic [15:0] cat;
    cat = {p, s};
    load(p);
    chk_msb(p[7]);
    for (int i = 0; i < 8; i++) begin
      i_serial_in <= s[7 - i];
      pulse(use_b);
      chk_msb(cat[14 - i]);
    end
    cyc(3);
    chk(p, sink_word, "stream word");
  endtask : t_shift

  task automatic t_disable;
    // top three bits alternate, so a missing or an extra shift shows on the output
    load(8'ha0);
    @(posedge i_clock);
    i_shift_clk_a <= 1'b1;
    cyc(4);
    chk_msb(1'b1);
    i_shift_clk_b <= 1'b1;
    cyc(4);
    chk_msb(1'b0);
    i_shift_clk_a <= 1'b0;
    cyc(4);
    pulse(1'b0);
    chk_msb(1'b0);
    i_shift_clk_b <= 1'b0;
    cyc(4);
    pulse(1'b0);
    chk_msb(1'b1);
  endtask : t_disable

  // enable dropped between the pin sample and the filtered edge: the shift must wait
  task automatic t_freeze;
    load(8'h80);
    @(posedge i_clock);
    i_shift_clk_a <= 1'b1;
    cyc(2);
    i_ce <= 1'b0;
    cyc(6);
    chk_msb(1'b1);
    i_ce <= 1'b1;
    cyc(4);
    chk_msb(1'b0);
    i_shift_clk_a <= 1'b0;
    cyc(5);
  endtask : t_freeze

  // mid-run reset: reset values show, no false edge after release, load and shift recover
  task automatic t_reset;
    load(8'h80);
    chk_msb(1'b1);
    i_rstn <= 1'b0;
    cyc(2);
    chk_msb(1'b0);
    chk(8'h01, {7'h00, o_stream_ready}, "ready in reset");
    chk(8'h00, {7'h00, o_stream_valid}, "valid in reset");
    i_rstn <= 1'b1;
    cyc(2);
    chk_msb(1'b0);
    load(8'h7f);
    chk_msb(1'b0);
    pulse(1'b1);
    chk_msb(1'b1);
  endtask : t_reset

  // consumer stalls, fifo fills, the ninth shift must be dropped
  task automatic t_full;
    logic [7:0] c0;
    stall <= 1'b1;
    load(8'h96);
    c0 = sink_count;
    for (int i = 0; i < 9; i++) begin
      i_serial_in <= (i == 0);
      pulse(1'b0);
    end
    chk(8'h00, {7'h00, o_stream_ready}, "fifo ready when full");
    chk_msb(1'b1);
    stall <= 1'b0;
    cyc(20);
    chk(c0 + 8'h08, sink_count, "drained count");
    chk(8'h96, sink_word, "drained word");
    chk(8'h00, {7'h00, o_stream_valid}, "fifo empty");
  endtask : t_full

  task automatic results;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  initial begin
    cyc(5);
    i_rstn <= 1'b1;
    cyc(5);
    t_load;
    t_shift(8'ha5, 8'h3c, 1'b0);
    t_shift(8'h5a, 8'hc3, 1'b1);
    t_disable;
    t_full;
    t_freeze;
    t_reset;
    results;
  end

  initial begin
    #(CLOCK_PERIOD_NS * 5000);
    miscompares++;
    $display("unexpected at %0t: watchdog expired", $time);
    results;
  end
endmodule : pisoshift_tb_top
